// [pkg/adc_cfg_defs.svh]
`ifndef ADC_CFG_DEFS_SVH
`define ADC_CFG_DEFS_SVH

// register offsets
`define ADDR_GLOBAL_CONTROL      8'h00
`define ADDR_OUTPUT_DRIVE_LEVEL  8'h01
`define ADDR_LANE_B              8'h25
`define ADDR_LANE_A              8'h2b
`define ADDR_LANE_D              8'h31
`define ADDR_LANE_C              8'h37
`define ADDR_DC_TRIM_SELECT      8'h3d
`define ADDR_USER_WORD_UPPER     8'h3f
`define ADDR_USER_WORD_LOWER     8'h40
`define ADDR_BURST_LONG_COUNT    8'h41
`define ADDR_POST_PROCESS_CTRL   8'h42
`define ADDR_BURST_PAIR_ENABLE   8'h44
`define ADDR_OVERLOAD_POWER_CTRL 8'h45
`define ADDR_TUNING_4A           8'h4a
`define ADDR_TUNING_62           8'h62
`define ADDR_TUNING_7A           8'h7a
`define ADDR_TUNING_92           8'h92
`define ADDR_STROBE_SKEW_PAIR1   8'ha9
`define ADDR_STROBE_SKEW_PAIR2   8'hac
`define ADDR_OVERLOAD_LEVEL      8'hc3
`define ADDR_OVERLOAD_LEVEL_EN   8'hc4
`define ADDR_TUNING_CF           8'hcf
`define ADDR_TUNING_D4           8'hd4
`define ADDR_TUNING_D5           8'hd5
`define ADDR_TUNING_D6           8'hd6
`define ADDR_TUNING_D7           8'hd7
`define ADDR_TUNING_DB           8'hdb
`define ADDR_BOOST_PIN_OVERRIDE  8'hea
`define ADDR_TUNING_F0           8'hf0
`define ADDR_DRIVE_LEVEL_UNLOCK  8'hf1
`define ADDR_TUNING_F5           8'hf5
`define ADDR_LANE_SLEEP          8'hfe

// field positions
`define BIT_READBACK_EN    0
`define BIT_SOFT_RESET     1
`define BIT_POST_EN        3
`define BIT_DC_TRIM_ON     5
`define BIT_BURST_AB       6
`define BIT_BURST_CD       7

// reset value of every register
`define REG_RESET_VALUE    8'h00

// pattern select codes
`define PAT_NORMAL         3'h0
`define PAT_ZEROS          3'h1
`define PAT_ONES           3'h2
`define PAT_TOGGLE         3'h3
`define PAT_RAMP           3'h4
`define PAT_USER           3'h5

// toggle words, first and second phase
`define TOG11_A            11'h555
`define TOG11_B            11'h2aa
`define TOG14_A            14'h1555
`define TOG14_B            14'h2aaa

// datapath figures
`define MID14              14'h2000
`define TRIM_TARGET14      16'sh1ff8
`define FULL14             14'h3fff
`define RAMP11_DIV_LAST    3'h7
`define GAIN_CODE_MAX      4'hc
`define SERIAL_ADDR_LAST   4'h7
`define SERIAL_WORD_LAST   4'hf

`endif

// [pkg/adc_cfg_pkg.sv]
package adc_cfg_pkg;

  // one lane's gain / pattern register
  typedef struct packed {
    logic [3:0] lane_gain_code;
    logic       lane_gain_skip;
    logic [2:0] lane_pattern_select;
  } lane_cfg_s;

  // serial word phase
  typedef enum logic {SH_ADDR, SH_DATA} shift_phase_e;

  typedef logic [3:0][13:0] lane_bus_t;

  // complete state of the register bank
  typedef struct packed {
    logic [255:0][7:0] regs;
    logic              sclk_q;
    logic [3:0]        bit_cnt;
    logic [14:0]       shift;
    shift_phase_e      phase;
    logic [7:0]        rd_byte;
    logic              sw_rst;
    logic              sdo;
    logic              sdo_oe;
    logic [2:0]        ramp_div;
    logic [10:0]       ramp11;
    logic [13:0]       ramp14;
    logic              tog;
    logic [3:0][21:0]  dc_acc;
    lane_bus_t         lane_out;
    logic [5:0]        drive_level;
  } bank_state_s;

endpackage

// [src/adc_config_register_bank.sv]
// Contract
// - read-back off tristates serial out, else drives
// - four lane registers, gain/skip/pattern fields
// - gain code in half-dB steps to 6 dB
// - skip bit bypasses the lane gain stage
// - pattern codes normal, all zeros, all ones
// - 14-bit toggle alternates 0101... / 1010...
// - 11-bit ramp steps every eighth clock
// - 14-bit ramp steps every clock
// - user word pattern, 13:3 or 13:0
// - user word split over two shared registers
// - post-processing bit gates gain and trim
// - trim maps mid-scale to code 1023
// - read-back blocks writes except global control
`timescale 1ns/1ps
`default_nettype none
`include "adc_cfg_defs.svh"

module adc_config_register_bank (
  input  wire logic                   clk,                // 10 mhz sample clock
  input  wire logic                   rst,                // synchronous, active high
  input  wire logic                   sen_n,              // serial enable, active low
  input  wire logic                   sclk,               // serial clock, sampled
  input  wire logic                   sdata,              // serial input data
  input  wire adc_cfg_pkg::lane_bus_t sample_in,          // converted samples, lanes a..d
  output var  logic                   serial_out_pin_o,   // read data level
  output var  logic                   serial_out_pin_oe,  // high while pin is driven
  output var  adc_cfg_pkg::lane_bus_t lane_out,           // lane words after processing
  output var  logic [5:0]             drive_level         // output swing setting
);
  import adc_cfg_pkg::*;

  bank_state_s s_r;                                        // registered state
  bank_state_s s_nxt;                                      // next state

  lane_bus_t        lane_word;                             // per-lane next output
  logic [3:0][21:0] acc_nxt;                               // per-lane next trim average

  // lane index 0..3 is a..d; map to its register offset
  function automatic logic [7:0] lane_addr(input int idx);
    logic [7:0] a;
    a = `ADDR_LANE_A;
    unique case (idx)
      0: a = `ADDR_LANE_A;
      1: a = `ADDR_LANE_B;
      2: a = `ADDR_LANE_C;
      default: a = `ADDR_LANE_D;
    endcase
    return a;
  endfunction

  // offsets that exist; anything else is not stored and reads zero
  function automatic logic is_mapped(input logic [7:0] a);
    logic m;
    m = 1'b0;
    case (a)
      `ADDR_GLOBAL_CONTROL, `ADDR_OUTPUT_DRIVE_LEVEL, `ADDR_LANE_B, `ADDR_LANE_A,
      `ADDR_LANE_D, `ADDR_LANE_C, `ADDR_DC_TRIM_SELECT, `ADDR_USER_WORD_UPPER,
      `ADDR_USER_WORD_LOWER, `ADDR_BURST_LONG_COUNT, `ADDR_POST_PROCESS_CTRL,
      `ADDR_BURST_PAIR_ENABLE, `ADDR_OVERLOAD_POWER_CTRL, `ADDR_TUNING_4A,
      `ADDR_TUNING_62, `ADDR_TUNING_7A, `ADDR_TUNING_92, `ADDR_STROBE_SKEW_PAIR1,
      `ADDR_STROBE_SKEW_PAIR2, `ADDR_OVERLOAD_LEVEL, `ADDR_OVERLOAD_LEVEL_EN,
      `ADDR_TUNING_CF, `ADDR_TUNING_D4, `ADDR_TUNING_D5, `ADDR_TUNING_D6,
      `ADDR_TUNING_D7, `ADDR_TUNING_DB, `ADDR_BOOST_PIN_OVERRIDE, `ADDR_TUNING_F0,
      `ADDR_DRIVE_LEVEL_UNLOCK, `ADDR_TUNING_F5, `ADDR_LANE_SLEEP:
        m = 1'b1;
      default:
        m = 1'b0;
    endcase
    return m;
  endfunction

  // linear gain factor, 1.0 = 1024, for a half-dB code
  function automatic logic [11:0] gain_factor(input logic [3:0] code);
    logic [11:0] f;
    f = 12'h400;
    case (code)
      4'h0: f = 12'h400;                                   // 0 db
      4'h1: f = 12'h43d;
      4'h2: f = 12'h47d;
      4'h3: f = 12'h4c1;
      4'h4: f = 12'h509;
      4'h5: f = 12'h555;
      4'h6: f = 12'h5a6;
      4'h7: f = 12'h5fc;
      4'h8: f = 12'h657;
      4'h9: f = 12'h6b7;
      4'ha: f = 12'h71e;
      4'hb: f = 12'h78a;
      default: f = 12'h7fb;                                // 6 db and every code above
    endcase
    return f;
  endfunction

  // scale a word about mid-scale and saturate to the 14-bit range
  function automatic logic [13:0] apply_gain(input logic [13:0] v, input logic [3:0] code);
    logic signed [14:0] d;
    logic signed [27:0] p;
    logic signed [17:0] r;
    logic [13:0]        o;
    d = $signed({1'b0, v}) - $signed({1'b0, `MID14});
    p = 28'(d) * 28'($signed({1'b0, gain_factor(code)}));
    r = 18'(p >>> 10) + $signed({4'h0, `MID14});
    if (r < 0)
      o = 14'h0000;
    else if (r > $signed({4'h0, `FULL14}))
      o = `FULL14;
    else
      o = r[13:0];
    return o;
  endfunction

  // remove the tracked average and recentre on the trim target
  function automatic logic [13:0] apply_trim(input logic [13:0] v, input logic [13:0] est);
    logic signed [15:0] c;
    logic [13:0]        o;
    c = $signed({2'b00, v}) - $signed({2'b00, est}) + `TRIM_TARGET14;
    if (c < 0)
      o = 14'h0000;
    else if (c > $signed({2'b00, `FULL14}))
      o = `FULL14;
    else
      o = c[13:0];
    return o;
  endfunction

  // per-lane datapath: trim, gain, then pattern override
  generate
    for (genvar g = 0; g < 4; g++)
    begin : g_lane
      lane_cfg_s   cfg;                                    // this lane's register
      logic        burst;                                  // 14-bit mode for this pair
      logic        post_en;                                // post-processing switched on
      logic        trim_en;                                // trim active on this lane
      logic [13:0] est;                                    // tracked average of input
      logic [13:0] trimmed;                                // after offset trim
      logic [13:0] scaled;                                 // after gain stage
      logic [13:0] user14;                                 // shared user word
      logic [13:0] sel;                                    // selected word

      assign cfg     = lane_cfg_s'(s_r.regs[lane_addr(g)]);
      assign burst   = (g < 2) ? s_r.regs[`ADDR_BURST_PAIR_ENABLE][`BIT_BURST_AB]
                               : s_r.regs[`ADDR_BURST_PAIR_ENABLE][`BIT_BURST_CD];
      assign post_en = s_r.regs[`ADDR_POST_PROCESS_CTRL][`BIT_POST_EN];
      // trim only makes sense on the 11-bit path, so burst lanes skip it
      assign trim_en = post_en & ~burst
                     & s_r.regs[`ADDR_DC_TRIM_SELECT][`BIT_DC_TRIM_ON];
      assign est     = s_r.dc_acc[g][21:8];
      assign user14  = {s_r.regs[`ADDR_USER_WORD_UPPER][5:0],
                        s_r.regs[`ADDR_USER_WORD_LOWER]};
      assign trimmed = trim_en ? apply_trim(sample_in[g], est) : sample_in[g];
      // gain waits for the post-processing bit, which the controller sets after the gain code
      assign scaled  = (post_en & ~cfg.lane_gain_skip)
                     ? apply_gain(trimmed, cfg.lane_gain_code) : trimmed;

      // leaky average with 1/256 weight; holds while trim is off
      assign acc_nxt[g] = trim_en ? (s_r.dc_acc[g] + 22'(sample_in[g]) - 22'(est))
                                  : s_r.dc_acc[g];

      // pattern mux; 11-bit words sit in the low bits
      always_comb
      begin
        sel = 14'h0000;
        unique case (cfg.lane_pattern_select)
          `PAT_ZEROS:  sel = 14'h0000;
          `PAT_ONES:   sel = burst ? `FULL14 : 14'(`FULL14 >> 3);
          `PAT_TOGGLE:
          begin
            if (burst)
              sel = s_r.tog ? `TOG14_B : `TOG14_A;
            else
              sel = {3'h0, (s_r.tog ? `TOG11_B : `TOG11_A)};
          end
          `PAT_RAMP:   sel = burst ? s_r.ramp14 : {3'h0, s_r.ramp11};
          `PAT_USER:   sel = burst ? user14 : {3'h0, user14[13:3]};
          // normal, and the two unused codes, pass the converted sample
          default:     sel = burst ? scaled : {3'h0, scaled[13:3]};
        endcase
      end
      assign lane_word[g] = sel;
    end
  endgenerate

  // next-state logic: serial shifter, register writes, pattern sources
  always_comb
  begin
    logic       fall;                                      // sclk falling edge seen
    logic       rise;                                      // sclk rising edge seen
    logic       readback;                                  // read-back mode active
    logic [7:0] waddr;                                     // address of completed word
    logic [7:0] wdata;                                     // data of completed word
    logic [7:0] raddr;                                     // address after eight bits
    fall     = 1'b0;
    rise     = 1'b0;
    readback = 1'b0;
    waddr    = 8'h00;
    wdata    = 8'h00;
    raddr    = 8'h00;
    s_nxt    = s_r;

    fall     = s_r.sclk_q & ~sclk;
    rise     = ~s_r.sclk_q & sclk;
    readback = s_r.regs[`ADDR_GLOBAL_CONTROL][`BIT_READBACK_EN];
    s_nxt.sclk_q = sclk;

    // pattern sources run free; lanes pick them up when selected
    s_nxt.tog      = ~s_r.tog;
    s_nxt.ramp14   = s_r.ramp14 + 14'h0001;
    s_nxt.ramp_div = s_r.ramp_div + 3'h1;
    if (s_r.ramp_div == `RAMP11_DIV_LAST)
      s_nxt.ramp11 = s_r.ramp11 + 11'h001;
    s_nxt.lane_out = lane_word;
    s_nxt.dc_acc   = acc_nxt;

    if (sen_n)
    begin
      // word framing restarts with every enable pulse; partial words are dropped
      s_nxt.bit_cnt = 4'h0;
      s_nxt.phase   = SH_ADDR;
      s_nxt.sdo     = 1'b0;
    end
    else if (fall)
    begin
      s_nxt.shift   = {s_r.shift[13:0], sdata};
      s_nxt.bit_cnt = s_r.bit_cnt + 4'h1;
      if (s_r.bit_cnt == `SERIAL_ADDR_LAST)
      begin
        // address complete: fetch the byte to send; global control is not readable
        raddr         = {s_r.shift[6:0], sdata};
        s_nxt.rd_byte = (raddr == `ADDR_GLOBAL_CONTROL) ? 8'h00 : s_r.regs[raddr];
        s_nxt.phase   = SH_DATA;
      end
      if (s_r.bit_cnt == `SERIAL_WORD_LAST)
      begin
        waddr       = s_r.shift[14:7];
        wdata       = {s_r.shift[6:0], sdata};
        s_nxt.phase = SH_ADDR;
        if (waddr == `ADDR_GLOBAL_CONTROL)
        begin
          // only the read-back bit is stored; the reset bit is a command
          s_nxt.regs[`ADDR_GLOBAL_CONTROL] = {7'h00, wdata[`BIT_READBACK_EN]};
          s_nxt.sw_rst = wdata[`BIT_SOFT_RESET];
        end
        else if (is_mapped(waddr) && !readback)
          s_nxt.regs[waddr] = wdata;
      end
    end
    else if (rise && s_r.phase == SH_DATA)
    begin
      // each rising edge of the data half presents the next bit, msb first
      s_nxt.sdo     = s_r.rd_byte[7];
      s_nxt.rd_byte = {s_r.rd_byte[6:0], 1'b0};
    end

    // soft reset lands one cycle after the write, then the bit reads as clear
    if (s_r.sw_rst)
    begin
      s_nxt.regs   = {256{`REG_RESET_VALUE}};
      s_nxt.sw_rst = 1'b0;
      s_nxt.dc_acc = '0;
    end

    // pin is driven only while read-back is on
    s_nxt.sdo_oe = s_nxt.regs[`ADDR_GLOBAL_CONTROL][`BIT_READBACK_EN];
    if (!s_nxt.sdo_oe)
      s_nxt.sdo = 1'b0;
    s_nxt.drive_level = s_nxt.regs[`ADDR_OUTPUT_DRIVE_LEVEL][7:2];
  end

  // single state register
  always_ff @(posedge clk)
  begin
    if (rst)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  // outputs straight from the state register
  assign serial_out_pin_o  = s_r.sdo;
  assign serial_out_pin_oe = s_r.sdo_oe;
  assign lane_out          = s_r.lane_out;
  assign drive_level       = s_r.drive_level;

endmodule

`default_nettype wire

// [verif/adc_cfg_bank_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
// port-level checks on the serial read path and register side effects
module adc_cfg_bank_assertions (
  input wire logic                   clk,
  input wire logic                   rst,
  input wire logic                   sen_n,
  input wire logic                   sclk,
  input wire logic                   serial_out_pin_o,
  input wire logic                   serial_out_pin_oe,
  input wire adc_cfg_pkg::lane_bus_t lane_out,
  input wire logic [5:0]             drive_level
);
  import adc_cfg_pkg::*;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // outputs leave reset cleared
  chk_reset_clears_out: assert property ($fell(rst) |-> lane_out == '0 && drive_level == 6'h00 && !serial_out_pin_oe)
    else $error("outputs not cleared after reset");
  // an undriven pin must not carry data
  chk_sdo_needs_oe: assert property (!serial_out_pin_oe |-> !serial_out_pin_o)
    else $error("read data while pin released");
  chk_sdo_idle_low: assert property (sen_n [*3] |-> !serial_out_pin_o)
    else $error("read data outside a frame");
  // a new read bit only follows a serial clock rise
  chk_sdo_waits_rise: assert property (!$past(sclk) && !$past(sclk, 2) && !$past(sen_n) && !$past(sen_n, 2) |-> $stable(serial_out_pin_o))
    else $error("read bit moved without a clock rise");
  chk_sdo_bit_holds: assert property ($rose(serial_out_pin_o) |=> serial_out_pin_o)
    else $error("read bit too short");
  // enable and swing only move shortly after a word inside a frame
  chk_oe_after_word: assert property ($changed(serial_out_pin_oe) |-> !$past(sen_n, 2) || !$past(sen_n, 3) || !$past(sen_n, 4))
    else $error("pin enable moved without a write");
  chk_drive_after_word: assert property ($changed(drive_level) |-> !$past(sen_n, 2) || !$past(sen_n, 3) || !$past(sen_n, 4))
    else $error("swing moved without a write");
  chk_oe_idle_stable: assert property (sen_n [*5] |-> $stable(serial_out_pin_oe))
    else $error("pin enable moved while idle");
endmodule
`default_nettype wire

// [verif/serial_ctrl_model.sv]
`timescale 1ns/1ps
`default_nettype none
// external controller on the serial configuration port
module serial_ctrl_model (
  input  wire logic clk,
  input  wire logic serial_out_pin_o,
  input  wire logic serial_out_pin_oe,
  output var  logic sen_n,
  output var  logic sclk,
  output var  logic sdata
);
  // idle: enable high, clock parked low
  initial
  begin
    sen_n = 1'b1;
    sclk  = 1'b0;
    sdata = 1'b0;
  end

  // one word, address then data, msb first; levels held 4 high / 3 low
  // clocks since the block only samples the serial clock
  task automatic xfer(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    logic [15:0] w;
    w = {a, d};
    q = 8'h00;
    @(posedge clk);
    sen_n <= 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      @(posedge clk);
      sdata <= w[i];
      sclk  <= 1'b1;
      repeat (4) @(posedge clk);
      // released pin reads unknown, so it never passes as data
      if (i < 8)
      begin
        q[i] = serial_out_pin_oe ? serial_out_pin_o : 1'bx;
      end
      sclk <= 1'b0;
      repeat (2) @(posedge clk);
    end
    @(posedge clk);
    sen_n <= 1'b1;
    // line released: show the inverse rather than the last bit
    sdata <= ~sdata;
  endtask
endmodule
`default_nettype wire

// [verif/adc_config_register_bank_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module adc_config_register_bank_tb_top;
  import adc_cfg_pkg::*;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       sen_n;
  logic       sclk;
  logic       sdata;
  lane_bus_t  sample_in = '0;
  lane_bus_t  lane_out;
  logic       serial_out_pin_o;
  logic       serial_out_pin_oe;
  logic [5:0] drive_level;
  int         err_total = 0;
  int         checks = 0;

  // 10 mhz clock
  always #50 clk = ~clk;

  adc_config_register_bank i_adc_config_register_bank (.clk, .rst, .sen_n, .sclk, .sdata,
    .sample_in, .serial_out_pin_o, .serial_out_pin_oe, .lane_out, .drive_level);
  serial_ctrl_model i_serial_ctrl_model (.clk, .serial_out_pin_o, .serial_out_pin_oe,
    .sen_n, .sclk, .sdata);

  task automatic chk(input string what, input logic [13:0] seen, input logic [13:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // one write word, then let lanes and swing settle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    i_serial_ctrl_model.xfer(a, d, q);
    repeat (3) @(posedge clk);
  endtask

  // read one register back over the serial pin; the data half of a word aimed
  // at global control is still written, so it keeps read-back switched on
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    i_serial_ctrl_model.xfer(a, (a == 8'h00) ? 8'h01 : 8'h00, q);
    chk("readback", {6'h0, q}, {6'h0, e});
    @(posedge clk);
  endtask

  // compare one lane word where outputs are settled
  task automatic lchk(input string what, input int n, input logic [13:0] e);
    @(negedge clk);
    chk(what, lane_out[n], e);
  endtask

  task automatic t_idle();
    chk("pin_idle", {12'h0, serial_out_pin_oe, serial_out_pin_o}, 14'h0);
    chk("drive_idle", {8'h0, drive_level}, 14'h0);
  endtask

  task automatic t_patterns();
    logic [13:0] v;
    @(posedge clk);
    sample_in <= {4{14'h2468}};
    wr(8'h2b, 8'h01);
    lchk("zeros", 0, 14'h0000);
    wr(8'h2b, 8'h02);
    lchk("ones", 0, 14'h07ff);
    wr(8'h2b, 8'h00);
    lchk("normal", 0, 14'h048d);
    for (int c = 6; c < 8; c++)
    begin
      wr(8'h37, 8'(c));
      lchk("unused_code", 2, 14'h048d);
    end
    wr(8'h2b, 8'h03);
    @(negedge clk);
    v = lane_out[0];
    chk("toggle11", {13'h0, v === 14'h0555 || v === 14'h02aa}, 14'h1);
    lchk("toggle11_next", 0, v ^ 14'h07ff);
    wr(8'h2b, 8'h04);
    @(negedge clk);
    v = lane_out[0];
    // line up on a step, then the word must hold for seven clocks
    for (int i = 0; i < 10 && lane_out[0] === v; i++)
      @(negedge clk);
    v = lane_out[0];
    repeat (6) @(negedge clk);
    lchk("ramp11_hold", 0, v);
    lchk("ramp11_step", 0, (v + 14'h1) & 14'h07ff);
    wr(8'h3f, 8'h2a);
    wr(8'h40, 8'hc5);
    wr(8'h2b, 8'h05);
    lchk("user11", 0, 14'h0558);
    wr(8'h44, 8'h40);
    lchk("user14", 0, 14'h2ac5);
    chk("normal14", lane_out[1], 14'h2468);
    wr(8'h31, 8'h02);
    lchk("ones_d", 3, 14'h07ff);
    wr(8'h44, 8'hc0);
    lchk("ones14_d", 3, 14'h3fff);
    wr(8'h2b, 8'h04);
    @(negedge clk);
    v = lane_out[0];
    lchk("ramp14", 0, v + 14'h1);
    wr(8'h2b, 8'h03);
    @(negedge clk);
    v = lane_out[0];
    chk("toggle14", {13'h0, v === 14'h1555 || v === 14'h2aaa}, 14'h1);
    lchk("toggle14_next", 0, v ^ 14'h3fff);
  endtask

  task automatic t_gain();
    logic [13:0] v;
    @(posedge clk);
    sample_in <= {4{14'h2400}};
    wr(8'h2b, 8'hc0);
    lchk("gain_post_off", 0, 14'h2400);
    wr(8'h42, 8'h08);
    @(negedge clk);
    v = lane_out[0];
    chk("gain_6db", {13'h0, v >= 14'h27f0 && v <= 14'h2800}, 14'h1);
    wr(8'h2b, 8'hf0);
    lchk("gain_clamp", 0, v);
    wr(8'h2b, 8'hc8);
    lchk("gain_skip", 0, 14'h2400);
    wr(8'h2b, 8'h00);
    lchk("gain_0db", 0, 14'h2400);
    // trim needs 11-bit lanes; a leaky average needs a few thousand clocks
    wr(8'h44, 8'h00);
    wr(8'h3d, 8'h20);
    sample_in <= {4{14'h2000}};
    repeat (3000) @(posedge clk);
    @(negedge clk);
    v = lane_out[0];
    chk("trim_mid", {13'h0, v >= 14'h03fe && v <= 14'h0400}, 14'h1);
    wr(8'h3d, 8'h00);
  endtask

  task automatic t_readback();
    wr(8'h01, 8'ha4);
    @(negedge clk);
    chk("drive_level", {8'h0, drive_level}, 14'h0029);
    // an unmapped offset must not keep what is written to it
    wr(8'h50, 8'h5a);
    wr(8'h00, 8'h01);
    @(negedge clk);
    chk("pin_on", {13'h0, serial_out_pin_oe}, 14'h1);
    wr(8'h25, 8'hff);
    rdc(8'h25, 8'h00);
    rdc(8'h37, 8'h07);
    rdc(8'h3f, 8'h2a);
    rdc(8'h01, 8'ha4);
    rdc(8'h00, 8'h00);
    rdc(8'h50, 8'h00);
    wr(8'h00, 8'h00);
    @(negedge clk);
    chk("pin_off", {12'h0, serial_out_pin_oe, serial_out_pin_o}, 14'h0);
  endtask

  task automatic t_soft_reset();
    wr(8'h00, 8'h02);
    @(negedge clk);
    chk("drive_sw_reset", {8'h0, drive_level}, 14'h0);
    wr(8'h00, 8'h01);
    rdc(8'h01, 8'h00);
    rdc(8'h37, 8'h00);
    rdc(8'h3f, 8'h00);
    wr(8'h00, 8'h00);
  endtask

  // main sequence, reset held four clocks
  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    t_idle();
    t_patterns();
    t_gain();
    t_readback();
    t_soft_reset();
    report_and_stop();
  end

  // run needs about 7700 clocks; give it over twice that
  initial
  begin
    repeat (20000) @(posedge clk);
    err_total++;
    report_and_stop();
  end
endmodule

bind adc_config_register_bank adc_cfg_bank_assertions i_adc_cfg_bank_assertions (.clk, .rst,
  .sen_n, .sclk, .serial_out_pin_o, .serial_out_pin_oe, .lane_out, .drive_level);
`default_nettype wire
